// ===== logic/comparator_control.sv
// Purpose: Register file, input selection and event logic around an analog comparator.
// Assumes: Analog decision arrives as a digital level cmp_raw from the analog cell.
// Notes:   Register port answers reads one cycle after the read strobe.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module comparator_control
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [cmp_pkg::ADDR_W-1:0] addr,
    input  wire logic [cmp_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr_stb,
    input  wire logic                       rd_stb,
    output logic      [cmp_pkg::DATA_W-1:0] rdata,
    input  wire logic                       cmp_raw,
    input  wire logic                       converter_enable,
    input  wire logic [2:0]                 channel_select,
    input  wire logic                       global_irq_enable,
    input  wire logic                       vector_taken,
    output logic                            comparator_power_on,
    output logic                            pos_bandgap_sel,
    output logic                            neg_mux_sel,
    output logic      [2:0]                 neg_channel,
    output logic                            capture_in,
    output logic                            comparator_irq,
    output logic                            event_irq
);

    // ************************************************************
    // Registers
    // ************************************************************
    cmp_pkg::csr_ctrl_s     ctrl_q;
    logic                   flag_q;
    logic [7:0]             sfc_q;
    logic [1:0]             stat_q;
    logic [1:0]             mask_q;
    logic [7:0]             rdata_q;
    logic                   result;
    logic                   rise;
    logic                   fall;
    logic                   hit;
    cmp_pkg::neg_sel_s      neg;

    function automatic logic mode_hit(input cmp_pkg::edge_mode_e m, input logic r, input logic f);
        case (m)
            cmp_pkg::MODE_TOGGLE:  mode_hit = r | f;
            cmp_pkg::MODE_FALLING: mode_hit = f;
            cmp_pkg::MODE_RISING:  mode_hit = r;
            default:               mode_hit = 1'b0;
        endcase
    endfunction : mode_hit

    wire wr_csr  = wr_stb && addr == cmp_pkg::IDX_CSR;
    wire wr_sfc  = wr_stb && addr == cmp_pkg::IDX_SFC;
    wire wr_mask = wr_stb && addr == cmp_pkg::IDX_IRQ_MASK;
    wire rd_stat = rd_stb && addr == cmp_pkg::IDX_IRQ_STAT;

    // ************************************************************
    // Synchroniser and edge classification
    // ************************************************************
    edge_detect u_edge
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .raw_in   (cmp_raw),
        .sync_out (result),
        .rise     (rise),
        .fall     (fall)
    );

    // Flag events are ignored while the comparator is powered down, since its output is meaningless then; stat_q still records edges.
    assign hit = mode_hit(ctrl_q.mode, rise, fall) & ~ctrl_q.disable_cmp;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_q <= cmp_pkg::csr_ctrl_s'(6'h00);
        end
        else if (wr_csr)
        begin
            ctrl_q.disable_cmp          <= wdata[cmp_pkg::CSR_DISABLE];
            ctrl_q.bandgap_select       <= wdata[cmp_pkg::CSR_BANDGAP];
            ctrl_q.irq_enable           <= wdata[cmp_pkg::CSR_IRQ_EN];
            ctrl_q.capture_route_enable <= wdata[cmp_pkg::CSR_CAPTURE];
            ctrl_q.mode <= cmp_pkg::edge_mode_e'(wdata[cmp_pkg::CSR_MODE_HI:cmp_pkg::CSR_MODE_LO]);
        end
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flag_q <= 1'b0;
        else if (hit)
            flag_q <= 1'b1;
        else if (vector_taken || (wr_csr && wdata[cmp_pkg::CSR_FLAG]))
            flag_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sfc_q <= cmp_pkg::SFC_RESET;
        else if (wr_sfc)
            sfc_q <= wdata & cmp_pkg::SFC_WMASK;
    end

    // ************************************************************
    // Sticky status and mask for the raw edge events
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stat_q <= cmp_pkg::ST_RESET;
        else
        begin
            stat_q[cmp_pkg::ST_RISE] <= rise | (stat_q[cmp_pkg::ST_RISE] & ~rd_stat);
            stat_q[cmp_pkg::ST_FALL] <= fall | (stat_q[cmp_pkg::ST_FALL] & ~rd_stat);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mask_q <= cmp_pkg::ST_RESET;
        else if (wr_mask)
            mask_q <= wdata[1:0];
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else if (rd_stb)
        begin
            if (addr == cmp_pkg::IDX_CSR)
                rdata_q <= {ctrl_q.disable_cmp, ctrl_q.bandgap_select, result, flag_q,
                            ctrl_q.irq_enable, ctrl_q.capture_route_enable, ctrl_q.mode};
            else if (addr == cmp_pkg::IDX_SFC)
                rdata_q <= sfc_q;
            else if (addr == cmp_pkg::IDX_IRQ_STAT)
                rdata_q <= {6'h00, stat_q};
            else
                rdata_q <= {6'h00, mask_q};
        end
        else
            rdata_q <= 8'h00;
    end

    // ************************************************************
    // Analog selections and outputs
    // ************************************************************
    assign neg.neg_mux_enable   = sfc_q[cmp_pkg::SFC_MUX_EN];
    assign neg.converter_enable = converter_enable;
    assign neg.channel_select   = channel_select;
    assign neg.use_mux          = neg.neg_mux_enable & ~neg.converter_enable;

    assign rdata               = rdata_q;
    assign comparator_power_on = ~ctrl_q.disable_cmp;
    assign pos_bandgap_sel     = ctrl_q.bandgap_select;
    assign neg_mux_sel         = neg.use_mux;
    assign neg_channel         = neg.use_mux ? neg.channel_select : 3'h0;
    assign capture_in          = ctrl_q.capture_route_enable & result;
    assign comparator_irq      = flag_q & ctrl_q.irq_enable & global_irq_enable;
    assign event_irq           = |(stat_q & mask_q);

endmodule : comparator_control
`default_nettype wire

// ===== inc/cmp_pkg.sv
// Purpose: Constants and carriers for the comparator control logic.
// Assumes: One 125 MHz core clock, synchronous active-low reset.
// Notes:   Register indices are local to this block's plain register port.
package cmp_pkg;

    localparam int          ADDR_W         = 2;
    localparam int          DATA_W         = 8;
    localparam int          CHAN_N         = 8;

    localparam logic [1:0]  IDX_CSR        = 2'h0;
    localparam logic [1:0]  IDX_SFC        = 2'h1;
    localparam logic [1:0]  IDX_IRQ_STAT   = 2'h2;
    localparam logic [1:0]  IDX_IRQ_MASK   = 2'h3;

    localparam int          CSR_DISABLE    = 7;
    localparam int          CSR_BANDGAP    = 6;
    localparam int          CSR_RESULT     = 5;
    localparam int          CSR_FLAG       = 4;
    localparam int          CSR_IRQ_EN     = 3;
    localparam int          CSR_CAPTURE    = 2;
    localparam int          CSR_MODE_HI    = 1;
    localparam int          CSR_MODE_LO    = 0;
    localparam int          SFC_MUX_EN     = 3;
    localparam logic [7:0]  SFC_WMASK      = 8'hEF;

    localparam logic [7:0]  CSR_RESET      = 8'h00;
    localparam logic [7:0]  SFC_RESET      = 8'h00;

    localparam int          ST_RISE        = 0;
    localparam int          ST_FALL        = 1;
    localparam logic [1:0]  ST_RESET       = 2'h0;

    typedef enum logic [1:0] {
        MODE_TOGGLE   = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALLING  = 2'b10,
        MODE_RISING   = 2'b11
    } edge_mode_e;

    typedef struct packed {
        logic                disable_cmp;
        logic                bandgap_select;
        logic                irq_enable;
        logic                capture_route_enable;
        edge_mode_e          mode;
    } csr_ctrl_s;

    typedef struct packed {
        logic                neg_mux_enable;
        logic                converter_enable;
        logic [2:0]          channel_select;
        logic                use_mux;
    } neg_sel_s;

endpackage : cmp_pkg

// ===== logic/edge_detect.sv
// Purpose: Synchronise the raw comparator decision and classify its edges.
// Assumes: Raw input is asynchronous to clk.
// Notes:   Output lags the input by one to two clocks.
`timescale 1ns/1ns
`default_nettype none
module edge_detect
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw_in,
    output logic      sync_out,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prev_q <= 1'b0;
        else
            prev_q <= sync_q;
    end

    assign sync_out = sync_q;
    assign rise     = sync_q & ~prev_q;
    assign fall     = ~sync_q & prev_q;
endmodule : edge_detect
`default_nettype wire

// ===== sim/analog_side_model.sv
// Purpose: Analog comparator and input multiplexer seen from the digital block.
// Assumes: Voltages in millivolts; channel n sits at 100*n+50.
// Notes:   Unpowered comparator reads low.
`timescale 1ns/1ns
`default_nettype none
module analog_side_model
#(
    parameter int BANDGAP_MV = 1100
)
(
    input  wire logic       power_on,
    input  wire logic       bg_sel,
    input  wire logic       mux_sel,
    input  wire logic [2:0] channel,
    input  wire integer     pos_mv,
    input  wire integer     neg_mv,
    output logic            cmp_raw
);
    int p;
    int n;
    assign p = bg_sel ? BANDGAP_MV : pos_mv;
    assign n = mux_sel ? 100 * int'(channel) + 50 : neg_mv;
    assign cmp_raw = power_on && (p > n);
endmodule : analog_side_model
`default_nettype wire

// ===== sim/comparator_control_properties.sv
// Purpose: Port-level checks of the comparator control block.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Bound to every instance.
`timescale 1ns/1ns
`default_nettype none
module comparator_checker
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       cmp_raw,
    input wire logic       converter_enable,
    input wire logic [2:0] channel_select,
    input wire logic       global_irq_enable,
    input wire logic       comparator_power_on,
    input wire logic       pos_bandgap_sel,
    input wire logic       neg_mux_sel,
    input wire logic [2:0] neg_channel,
    input wire logic       capture_in,
    input wire logic       comparator_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_irq; comparator_irq |-> global_irq_enable; endproperty
    a_irq: assert property (p_irq) else $error("irq without global enable");
    property p_mux; neg_mux_sel |-> !converter_enable; endproperty
    a_mux: assert property (p_mux) else $error("mux with converter on");
    property p_chan; neg_mux_sel |-> neg_channel == channel_select; endproperty
    a_chan: assert property (p_chan) else $error("wrong channel");
    property p_dis; wr_stb && addr == cmp_pkg::IDX_CSR |=> comparator_power_on == !$past(wdata[7]); endproperty
    a_dis: assert property (p_dis) else $error("power state wrong");
    property p_bg; wr_stb && addr == cmp_pkg::IDX_CSR |=> pos_bandgap_sel == $past(wdata[6]); endproperty
    a_bg: assert property (p_bg) else $error("bandgap select wrong");
    property p_cap; capture_in |-> $past(cmp_raw) || $past(cmp_raw, 2) || $past(cmp_raw, 3); endproperty
    a_cap: assert property (p_cap) else $error("capture without result");
    property p_idle; !rd_stb |=> rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
    property p_rd; rd_stb && addr == cmp_pkg::IDX_CSR |=> rdata[7:6] == {!comparator_power_on, pos_bandgap_sel};
    endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
endmodule : comparator_checker
bind comparator_control comparator_checker i_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cmp_raw(cmp_raw), .converter_enable(converter_enable),
    .channel_select(channel_select), .global_irq_enable(global_irq_enable),
    .comparator_power_on(comparator_power_on), .pos_bandgap_sel(pos_bandgap_sel), .neg_mux_sel(neg_mux_sel),
    .neg_channel(neg_channel), .capture_in(capture_in), .comparator_irq(comparator_irq));
`default_nettype wire

// ===== sim/tb.sv
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Bench model mirrors the analog side model voltages.
// Notes:   Interrupt enable is cleared before mode changes.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk, rst_n, wr_stb, rd_stb, converter_enable, global_irq_enable, vector_taken;
    logic cmp_raw, comparator_power_on, pos_bandgap_sel, neg_mux_sel, capture_in, comparator_irq, event_irq;
    logic [1:0] addr;
    logic [2:0] channel_select, neg_channel;
    logic [7:0] wdata, rdata, d, rnd;
    int pos_mv, neg_mv, n_mismatch, check_count, m;
    logic capture_irq_mask, capture_irq;
    // Stand-in for the timer's capture interrupt gate, which the block itself does not own.
    assign capture_irq = capture_in & capture_irq_mask;
    comparator_control i_comparator_control (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cmp_raw(cmp_raw), .converter_enable(converter_enable),
        .channel_select(channel_select), .global_irq_enable(global_irq_enable), .vector_taken(vector_taken),
        .comparator_power_on(comparator_power_on), .pos_bandgap_sel(pos_bandgap_sel), .neg_mux_sel(neg_mux_sel),
        .neg_channel(neg_channel), .capture_in(capture_in), .comparator_irq(comparator_irq), .event_irq(event_irq));
    analog_side_model #(.BANDGAP_MV(1100)) i_analog_side_model (.power_on(comparator_power_on),
        .bg_sel(pos_bandgap_sel), .mux_sel(neg_mux_sel), .channel(neg_channel), .pos_mv(pos_mv), .neg_mv(neg_mv),
        .cmp_raw(cmp_raw));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk) addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk) wr_stb <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [1:0] a);
        @(posedge clk) addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk) rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic set_v(input int p, input int n);
        @(posedge clk) pos_mv <= p;
        neg_mv <= n;
        repeat (6) @(posedge clk);
        #1;
    endtask : set_v
    task automatic end_of_test;
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #200000 n_mismatch++;
        end_of_test();
    end
    initial
    begin
        {rst_n, wr_stb, rd_stb, converter_enable, global_irq_enable, vector_taken} = '0;
        {addr, wdata, channel_select} = '0;
        pos_mv = 200;
        neg_mv = 300;
        rnd = 8'h22;
        capture_irq_mask = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(cmp_pkg::IDX_SFC);
        chk(d, 8'h00);
        set_v(600, 300);
        rd(cmp_pkg::IDX_CSR);
        chk(d, 8'h30);
        for (m = 0; m < 4; m++)
        begin
            wr(cmp_pkg::IDX_CSR, 8'(m));
            set_v(200, 300);
            wr(cmp_pkg::IDX_CSR, 8'h10 | 8'(m));
            set_v(600, 300);
            rd(cmp_pkg::IDX_CSR);
            chk(d, {3'b001, m == 0 || m == 3, 2'b00, 2'(m)});
            wr(cmp_pkg::IDX_CSR, 8'h10 | 8'(m));
            set_v(200, 300);
            rd(cmp_pkg::IDX_CSR);
            chk(d, {3'b000, m == 0 || m == 2, 2'b00, 2'(m)});
        end
        wr(cmp_pkg::IDX_CSR, 8'h10);
        wr(cmp_pkg::IDX_CSR, 8'h08);
        rnd = lfsr(rnd);
        global_irq_enable <= rnd[0];
        set_v(600, 300);
        chk(8'(comparator_irq), 8'(rnd[0]));
        global_irq_enable <= 1'b1;
        wr(cmp_pkg::IDX_CSR, 8'h08);
        chk(8'(comparator_irq), 8'h01);
        @(posedge clk) vector_taken <= 1'b1;
        @(posedge clk) vector_taken <= 1'b0;
        #1 chk(8'(comparator_irq), 8'h00);
        set_v(200, 300);
        wr(cmp_pkg::IDX_CSR, 8'h1C);
        chk(8'(comparator_irq), 8'h00);
        set_v(600, 300);
        chk(8'(capture_in), 8'h01);
        chk(8'(capture_irq), 8'h01);
        wr(cmp_pkg::IDX_CSR, 8'h40);
        set_v(200, 300);
        chk({capture_in, pos_bandgap_sel, cmp_raw}, 3'b011);
        wr(cmp_pkg::IDX_CSR, 8'h00);
        wr(cmp_pkg::IDX_SFC, 8'h08);
        for (m = 0; m < 8; m++)
        begin
            rnd = lfsr(rnd);
            channel_select <= rnd[2:0];
            converter_enable <= rnd[3];
            set_v(400, 900);
            rd(cmp_pkg::IDX_CSR);
            chk({neg_mux_sel, d[5]}, {!rnd[3], rnd[3] ? 1'b0 : 400 > 100 * int'(rnd[2:0]) + 50});
        end
        wr(cmp_pkg::IDX_IRQ_MASK, 8'h01);
        set_v(200, 300);
        rd(cmp_pkg::IDX_IRQ_STAT);
        set_v(600, 300);
        chk(8'(event_irq), 8'h01);
        rd(cmp_pkg::IDX_IRQ_STAT);
        chk(d, 8'h01);
        set_v(200, 300);
        chk(8'(event_irq), 8'h00);
        wr(cmp_pkg::IDX_CSR, 8'h80);
        rd(cmp_pkg::IDX_CSR);
        chk({comparator_power_on, d}, 9'h090);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
